/* core/clps_defs.svh */
/*
  timing and field constants for the core low power signalling block.
  assumes inclusion by bare name from core/ design files.
*/
`ifndef CLPS_DEFS_SVH
`define CLPS_DEFS_SVH
`define CLPS_STS_RP_POS      27
`define CLPS_STS_EXL_POS     1
`define CLPS_STS_ERL_POS     2
`define CLPS_DBG_DM_POS      30
`define CLPS_STS_RST         32'h0000_0004
`define CLPS_DBG_RST         32'h0000_0000
`define CLPS_NUM_INT         6
`define CLPS_RATIO_RST       5'h02
`define CLPS_RATIO_MAX       5'h14
`endif

/* core/clps_pkg.sv */
/*
  types for the core low power signalling block.
  assumes clps_defs.svh holds the numeric constants.
*/
package clps_pkg;
  typedef enum logic [3:0] {
    CLPS_RUN   = 4'b0001,
    CLPS_DRAIN = 4'b0010,
    CLPS_QUIET = 4'b0100,
    CLPS_SLEEP = 4'b1000
  } clps_state_t;
  typedef struct packed {
    logic       intr_any;
    logic       nmi;
    logic       rst_req;
  } clps_wake_t;
  typedef struct packed {
    logic rp;
    logic exception_level_bit;
    logic error_level_bit;
    logic dm;
  } clps_pwr_t;
endpackage : clps_pkg

/* core/clps_sync.sv */
/*
  two flop synchroniser, vector width parameter.
  assumes a single destination clock domain.
*/
`timescale 1ns/1ps
module clps_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;
  // first stage read only by second stage
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta <= '0;
      o_q  <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule : clps_sync

/* core/clps_core_low_power.sv */
/*
  power state export, halt-until-event sleep sequencing and bus ratio helper.
  assumes status/debug writes and exception entry come from core logic on
  i_clk_sys; wake pins are asynchronous and synchronised here.
*/
`timescale 1ns/1ps
`include "clps_defs.svh"
module clps_core_low_power (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_sts_we,
  input  wire logic [31:0] i_sts_wdata,
  input  wire logic        i_dbg_we,
  input  wire logic [31:0] i_dbg_wdata,
  input  wire logic        i_exc_take,
  input  wire logic        i_exc_to_erl,
  input  wire logic        i_exc_to_dm,
  input  wire logic        i_eret,
  input  wire logic        i_deret,
  input  wire logic        i_halt_fetched,
  input  wire logic        i_halt_graduated,
  input  wire logic        i_bus_busy,
  input  wire logic        i_insn_in_flight,
  input  wire logic [5:0]  i_int_pin,
  input  wire logic        i_nmi_pin,
  input  wire logic        i_reset_pin,
  input  wire logic [4:0]  i_bus_ratio,
  output logic      [31:0] o_status,
  output logic      [31:0] o_debug,
  output logic             o_low_power_request_out,
  output logic             o_exception_level_out,
  output logic             o_error_level_out,
  output logic             o_debug_state_out,
  output logic             o_fetch_stop,
  output logic             o_core_clk_en,
  output logic             o_sleep,
  output logic             o_wake,
  output logic             o_bus_helper_pulse
);
  // architectural bits
  logic [31:0]           status;
  logic [31:0]           debug;
  clps_pkg::clps_state_t state;
  clps_pkg::clps_state_t next_state;
  clps_pkg::clps_pwr_t   pwr;
  clps_pkg::clps_wake_t  wake_s;
  logic [7:0]            wake_q;
  logic [4:0]            ratio;
  logic [4:0]            phase;
  logic [4:0]            next_phase;

  // asynchronous wake pins pass two flops
  clps_sync #(
    .W (8)
  ) u_wake_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_d       ({i_int_pin, i_nmi_pin, i_reset_pin}),
    .o_q       (wake_q)
  );

  // wake causes
  assign wake_s.intr_any = |wake_q[7:2];
  assign wake_s.nmi      = wake_q[1];
  assign wake_s.rst_req  = wake_q[0];
  assign o_wake          = (state == clps_pkg::CLPS_SLEEP) && (|wake_s);

  // status register: software write, exception entry wins over return
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      status <= `CLPS_STS_RST;
    else
    begin
      if (i_sts_we)
        status <= i_sts_wdata;
      if (i_eret && !i_sts_we)
        status[`CLPS_STS_EXL_POS] <= 1'b0;
      if (i_eret && !i_sts_we && !status[`CLPS_STS_EXL_POS])
        status[`CLPS_STS_ERL_POS] <= 1'b0;
      if (i_exc_take && !i_exc_to_dm && !i_exc_to_erl)
        status[`CLPS_STS_EXL_POS] <= 1'b1;
      if (i_exc_take && !i_exc_to_dm && i_exc_to_erl)
        status[`CLPS_STS_ERL_POS] <= 1'b1;
    end
  end

  // debug register: debug exception sets dm, return clears it
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      debug <= `CLPS_DBG_RST;
    else
    begin
      if (i_dbg_we)
        debug <= i_dbg_wdata;
      else if (i_deret)
        debug[`CLPS_DBG_DM_POS] <= 1'b0;
      if (i_exc_take && i_exc_to_dm)
        debug[`CLPS_DBG_DM_POS] <= 1'b1;
    end
  end

  // power outputs track the bits combinationally from registers
  assign pwr.rp  = status[`CLPS_STS_RP_POS];
  assign pwr.exception_level_bit = status[`CLPS_STS_EXL_POS];
  assign pwr.error_level_bit = status[`CLPS_STS_ERL_POS];
  assign pwr.dm  = debug[`CLPS_DBG_DM_POS];
  assign o_low_power_request_out = pwr.rp;
  assign o_exception_level_out   = pwr.exception_level_bit;
  assign o_error_level_out       = pwr.error_level_bit;
  assign o_debug_state_out       = pwr.dm;
  assign o_status = status;
  assign o_debug  = debug;

  // halt sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      clps_pkg::CLPS_RUN:
        if (i_halt_fetched)
          next_state = clps_pkg::CLPS_DRAIN;
      clps_pkg::CLPS_DRAIN:
        if (i_halt_graduated)
          next_state = clps_pkg::CLPS_QUIET;
      clps_pkg::CLPS_QUIET:
        if (|wake_s)
          next_state = clps_pkg::CLPS_RUN;
        else if (!i_bus_busy && !i_insn_in_flight)
          next_state = clps_pkg::CLPS_SLEEP;
      clps_pkg::CLPS_SLEEP:
        if (|wake_s)
          next_state = clps_pkg::CLPS_RUN;
      default:
        next_state = clps_pkg::CLPS_RUN;
    endcase
  end

  // state flops: all state static, held while clock stopped
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state <= clps_pkg::CLPS_RUN;
    else
      state <= next_state;
  end

  assign o_fetch_stop  = (state != clps_pkg::CLPS_RUN);
  assign o_sleep       = (state == clps_pkg::CLPS_SLEEP);
  assign o_core_clk_en = (state != clps_pkg::CLPS_SLEEP);

  // bus helper pulse: ratio in half steps, 2 means 1:1, 20 means 1:10
  assign ratio = (i_bus_ratio < `CLPS_RATIO_RST) ? `CLPS_RATIO_RST :
                 (i_bus_ratio > `CLPS_RATIO_MAX) ? `CLPS_RATIO_MAX : i_bus_ratio;
  assign next_phase = (phase + 5'h02 >= ratio) ? 5'(phase + 5'h02 - ratio) : 5'(phase + 5'h02);

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      phase              <= 5'h00;
      o_bus_helper_pulse <= 1'b0;
    end
    else
    begin
      phase              <= next_phase;
      o_bus_helper_pulse <= (phase + 5'h02 >= ratio);
    end
  end

  // checks
  property p_rp_mirror;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_sts_we |=> o_low_power_request_out == $past(i_sts_wdata[`CLPS_STS_RP_POS]);
  endproperty
  a_rp_mirror: assert property (p_rp_mirror) else $error("request pin not following bit");

  property p_exc_sets;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_exc_take && !i_exc_to_dm && !i_exc_to_erl) |=> o_exception_level_out;
  endproperty
  a_exc_sets: assert property (p_exc_sets) else $error("exception level not set");

  property p_dm_sets;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_exc_take && i_exc_to_dm) |=> o_debug_state_out;
  endproperty
  a_dm_sets: assert property (p_dm_sets) else $error("debug state not set");

  property p_dm_clear;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_deret && !i_dbg_we && !i_exc_take) |=> !o_debug_state_out;
  endproperty
  a_dm_clear: assert property (p_dm_clear) else $error("debug state not cleared");

  property p_sleep_quiet;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(o_sleep) |-> $past(!i_bus_busy && !i_insn_in_flight);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep while busy");

  property p_fetch_stop;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (state == clps_pkg::CLPS_RUN && i_halt_fetched) |=> o_fetch_stop;
  endproperty
  a_fetch_stop: assert property (p_fetch_stop) else $error("fetch not stopped");

  property p_grad_wait;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (state == clps_pkg::CLPS_DRAIN && !i_halt_graduated) |=> !o_sleep;
  endproperty
  a_grad_wait: assert property (p_grad_wait) else $error("sleep before graduation");

  property p_wake;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_wake |=> !o_sleep && o_core_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("sleep kept after wake");

  property p_clk_off;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_sleep |-> !o_core_clk_en;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("core clock running in sleep");

  // clock stays suspended until a wake source shows up
  property p_sleep_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_sleep && !o_wake) |=> o_sleep;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without wake");

  // equal rates need a helper pulse on every core cycle
  property p_helper_full;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_bus_ratio <= `CLPS_RATIO_RST) |=> o_bus_helper_pulse;
  endproperty
  a_helper_full: assert property (p_helper_full) else $error("helper pulse missing at equal rates");
endmodule : clps_core_low_power

/* sim/clps_agent.sv */
/*
  external power agent model: picks bus ratio from the power pins.
  assumes pins come straight from clps_core_low_power.
*/
`timescale 1ns/1ps
module clps_agent (
  input  wire logic       i_rp,
  input  wire logic       i_exl,
  input  wire logic       i_erl,
  input  wire logic       i_dm,
  output logic            o_slow,
  output logic      [4:0] o_ratio
);
  // slow the bus on request unless an exception waits
  assign o_slow  = i_rp & ~(i_exl | i_erl | i_dm);
  assign o_ratio = o_slow ? 5'h14 : 5'h02;
endmodule : clps_agent

/* sim/clps_tb.sv */
/*
  self-checking bench for clps_core_low_power with the agent model.
  assumes the 40 MHz clock and inputs driven 2 ns after each rising edge.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  logic        i_clk_sys, i_rst_n, i_sts_we, i_dbg_we, i_exc_take, i_exc_to_erl, i_exc_to_dm;
  logic        i_eret, i_deret, i_halt_fetched, i_halt_graduated, i_bus_busy, i_insn_in_flight;
  logic        i_nmi_pin, i_reset_pin, o_low_power_request_out, o_exception_level_out;
  logic        o_error_level_out, o_debug_state_out, o_fetch_stop, o_core_clk_en, o_sleep;
  logic        o_wake, o_bus_helper_pulse, slow;
  logic [31:0] i_sts_wdata, i_dbg_wdata, o_status, o_debug;
  logic [5:0]  i_int_pin;
  logic [4:0]  i_bus_ratio;
  int          error_cnt, n_tests, cnt;
  // device and agent
  clps_core_low_power dut (
    .i_clk_sys               (i_clk_sys),
    .i_rst_n                 (i_rst_n),
    .i_sts_we                (i_sts_we),
    .i_sts_wdata             (i_sts_wdata),
    .i_dbg_we                (i_dbg_we),
    .i_dbg_wdata             (i_dbg_wdata),
    .i_exc_take              (i_exc_take),
    .i_exc_to_erl            (i_exc_to_erl),
    .i_exc_to_dm             (i_exc_to_dm),
    .i_eret                  (i_eret),
    .i_deret                 (i_deret),
    .i_halt_fetched          (i_halt_fetched),
    .i_halt_graduated        (i_halt_graduated),
    .i_bus_busy              (i_bus_busy),
    .i_insn_in_flight        (i_insn_in_flight),
    .i_int_pin               (i_int_pin),
    .i_nmi_pin               (i_nmi_pin),
    .i_reset_pin             (i_reset_pin),
    .i_bus_ratio             (i_bus_ratio),
    .o_status                (o_status),
    .o_debug                 (o_debug),
    .o_low_power_request_out (o_low_power_request_out),
    .o_exception_level_out   (o_exception_level_out),
    .o_error_level_out       (o_error_level_out),
    .o_debug_state_out       (o_debug_state_out),
    .o_fetch_stop            (o_fetch_stop),
    .o_core_clk_en           (o_core_clk_en),
    .o_sleep                 (o_sleep),
    .o_wake                  (o_wake),
    .o_bus_helper_pulse      (o_bus_helper_pulse)
  );
  clps_agent agent (.i_rp(o_low_power_request_out), .i_exl(o_exception_level_out),
    .i_erl(o_error_level_out), .i_dm(o_debug_state_out), .o_slow(slow), .o_ratio(i_bus_ratio));
  // clock source
  initial
  begin
    i_clk_sys = 0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  task step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask : step
  task tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // helper pulses seen over 200 cycles
  task count_helper;
    cnt = 0;
    repeat (200)
    begin
      step(1);
      cnt += o_bus_helper_pulse;
    end
  endtask : count_helper
  // wait for sleep to reach a level, bounded
  task wait_sleep(input logic lvl);
    for (int i = 0; i < 10 && o_sleep !== lvl; i++) step(1);
  endtask : wait_sleep
  // watchdog
  initial
  begin
    repeat (5000) @(posedge i_clk_sys);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    {i_rst_n, i_sts_we, i_dbg_we, i_exc_take, i_exc_to_erl, i_exc_to_dm, i_eret, i_deret} = '0;
    {i_halt_fetched, i_halt_graduated, i_bus_busy, i_insn_in_flight, i_nmi_pin, i_reset_pin} = '0;
    {i_sts_wdata, i_dbg_wdata, i_int_pin} = '0;
    step(6);
    i_rst_n = 1;
    step(1);
    `CHK({o_low_power_request_out, o_exception_level_out, o_error_level_out, o_debug_state_out}, 4'h2)
    `CHK({o_sleep, o_core_clk_en, o_status}, {2'b01, 32'h0000_0004})
    count_helper();
    `CHK(cnt >= 199, 1'b1)
    // request low power; agent slows the bus
    i_sts_wdata = 32'h0800_0000;
    i_sts_we = 1;
    step(1);
    i_sts_we = 0;
    step(1);
    `CHK({o_low_power_request_out, o_error_level_out, slow}, 3'b101)
    count_helper();
    `CHK(cnt >= 19 && cnt <= 21, 1'b1)
    // each exception kind, then its return
    for (int k = 0; k < 3; k++)
    begin
      {i_exc_take, i_exc_to_erl, i_exc_to_dm} = {1'b1, k == 1, k == 2};
      step(1);
      i_exc_take = 0;
      step(1);
      `CHK({o_exception_level_out, o_error_level_out, o_debug_state_out, slow}, {3'b100 >> k, 1'b0})
      `CHK({o_status[1], o_status[2], o_debug[30]}, 3'b100 >> k)
      {i_eret, i_deret} = {k != 2, k == 2};
      step(1);
      {i_eret, i_deret} = 2'b00;
      step(1);
      `CHK({o_exception_level_out, o_error_level_out, o_debug_state_out, slow}, 4'h1)
    end
    // debug word write sets and clears its pin
    for (int k = 1; k >= 0; k--)
    begin
      i_dbg_wdata = k ? 32'h4000_0000 : 32'h0;
      i_dbg_we = 1;
      step(1);
      i_dbg_we = 0;
      step(1);
      `CHK(o_debug_state_out, k[0])
    end
    // exception in the same cycle as a status write keeps its bit
    {i_sts_we, i_exc_take, i_exc_to_erl, i_exc_to_dm} = 4'b1100;
    step(1);
    {i_sts_we, i_exc_take} = 2'b00;
    `CHK({o_low_power_request_out, o_exception_level_out, o_error_level_out}, 3'b110)
    i_eret = 1;
    step(1);
    i_eret = 0;
    `CHK(o_exception_level_out, 1'b0)
    // graduation without a fetched halt is ignored
    i_halt_graduated = 1;
    step(1);
    i_halt_graduated = 0;
    step(3);
    `CHK({o_fetch_stop, o_sleep}, 2'b00)
    // halt walk, woken by every source in turn
    for (int w = 0; w < 8; w++)
    begin
      {i_bus_busy, i_insn_in_flight, i_halt_fetched} = 3'b111;
      step(1);
      i_halt_fetched = 0;
      step(1);
      `CHK({o_fetch_stop, o_sleep}, 2'b10)
      i_halt_graduated = 1;
      step(1);
      i_halt_graduated = 0;
      step(4);
      `CHK(o_sleep, 1'b0)
      i_bus_busy = 0;
      step(4);
      `CHK(o_sleep, 1'b0)
      i_insn_in_flight = 0;
      wait_sleep(1'b1);
      `CHK({o_sleep, o_core_clk_en}, 2'b10)
      {i_reset_pin, i_nmi_pin, i_int_pin} = 8'h01 << w;
      step(2);
      `CHK({o_wake, o_sleep}, 2'b11)
      wait_sleep(1'b0);
      `CHK({o_sleep, o_core_clk_en, o_fetch_stop, o_wake}, 4'b0100)
      {i_reset_pin, i_nmi_pin, i_int_pin} = '0;
      step(4);
    end
    // wake while the bus still drains returns without sleep
    {i_bus_busy, i_halt_fetched} = 2'b11;
    step(1);
    {i_halt_fetched, i_halt_graduated} = 2'b01;
    step(1);
    i_halt_graduated = 0;
    i_int_pin = 6'h01;
    step(4);
    `CHK({o_fetch_stop, o_sleep, o_wake}, 3'b000)
    {i_bus_busy, i_int_pin} = '0;
    step(4);
    tally_and_finish();
  end
endmodule : testbench
